// ### verilog/anxs_pkg.sv
// Constants for the negotiation next-page and expansion status block.
// Assumes one 125 MHz clock and a synchronous active-low reset.
package anxs_pkg;
	// ==========================================
	// Register map
	localparam logic [4:0]  ANXS_PARTNER_NEXT_PAGE_ADDR = 5'h05;
	localparam logic [4:0]  ANXS_EXPANSION_ADDR         = 5'h06;
	localparam logic [15:0] ANXS_PARTNER_RESET          = 16'h0000;
	// ==========================================
	// Partner next-page fields
	localparam int ANXS_NP_REQ_BIT   = 15;
	localparam int ANXS_NP_ACK_BIT   = 14;
	localparam int ANXS_MSG_PAGE_BIT = 13;
	localparam int ANXS_COMPLY_ACK_BIT = 12;
	localparam int ANXS_TOGGLE_BIT   = 11;
	localparam int ANXS_CODE_MSB     = 10;
	// ==========================================
	// Expansion fields
	localparam int ANXS_PD_FAULT_BIT   = 4;
	localparam int ANXS_PARTNER_NP_BIT = 3;
	localparam int ANXS_LOCAL_NP_BIT   = 2;
	localparam int ANXS_PAGE_RX_BIT    = 1;
	localparam int ANXS_PARTNER_AN_BIT = 0;
	localparam logic ANXS_LOCAL_NP_VALUE = 1'b1;
endpackage

// ### verilog/anxs_sticky_flag.sv
// Sticky status flag: hardware sets, a clear strobe clears.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module anxs_sticky_flag (
	input  wire logic core_clk_in, // 125 MHz clock
	input  wire logic rst_b_in,    // Synchronous reset, active low
	input  wire logic set_in,      // Set pulse
	input  wire logic clear_in,    // Clear pulse
	output logic      flag_out     // Flag state
);
	// Set beats clear so an event in the clearing cycle survives
	wire logic next_flag = set_in | (flag_out & ~clear_in);

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			flag_out <= 1'b0;
		end else begin
			flag_out <= next_flag;
		end
	end
endmodule

// ### verilog/anxs_status_regs.sv
// Partner next-page and negotiation expansion status registers.
// Assumes negotiation logic and the management read path share core_clk_in.
`timescale 1ns/1ps
module anxs_status_regs
	import anxs_pkg::*;
(
	input  wire logic        core_clk_in,         // 125 MHz clock
	input  wire logic        rst_b_in,            // Synchronous reset, active low
	input  wire logic        page_valid_in,       // Received code word pulse
	input  wire logic [15:0] page_word_in,        // Received code word
	input  wire logic        parallel_fault_in,   // Parallel detect fault pulse
	input  wire logic        partner_np_cap_in,   // Partner extra pages capable
	input  wire logic        partner_an_cap_in,   // Partner negotiation capable
	input  wire logic [4:0]  reg_addr_in,         // Register address
	input  wire logic        reg_rd_in,           // Read strobe
	input  wire logic        reg_wr_in,           // Write strobe, ignored
	input  wire logic [15:0] reg_wdata_in,        // Write data, ignored
	output logic [15:0]      reg_rdata_out,       // Read data, one cycle later
	output logic             reg_rvalid_out       // Read data valid pulse
);
	import anxs_pkg::*;

	// ==========================================
	// Partner next page capture
	logic [15:0] partner_next_page_received;
	logic        partner_extra_pages_capable;
	logic        partner_negotiation_capable;
	logic        parallel_detect_fault;
	logic        page_received;

	// Whole word taken from the link; software writes never reach it
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			partner_next_page_received <= ANXS_PARTNER_RESET;
		end else if (page_valid_in) begin
			partner_next_page_received <= page_word_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			partner_extra_pages_capable <= 1'b0;
			partner_negotiation_capable <= 1'b0;
		end else begin
			partner_extra_pages_capable <= partner_np_cap_in;
			partner_negotiation_capable <= partner_an_cap_in;
		end
	end

	// ==========================================
	// Decode
	wire logic sel_partner   = (reg_addr_in == ANXS_PARTNER_NEXT_PAGE_ADDR);
	wire logic sel_expansion = (reg_addr_in == ANXS_EXPANSION_ADDR);
	wire logic clear_page_rx = reg_rd_in & sel_expansion;
	wire logic unused_write  = reg_wr_in & (|reg_wdata_in);

	// Fault stays latched until reset
	anxs_sticky_flag u_fault (
		.core_clk_in (core_clk_in),
		.rst_b_in    (rst_b_in),
		.set_in      (parallel_fault_in),
		.clear_in    (1'b0),
		.flag_out    (parallel_detect_fault)
	);

	anxs_sticky_flag u_page_rx (
		.core_clk_in (core_clk_in),
		.rst_b_in    (rst_b_in),
		.set_in      (page_valid_in),
		.clear_in    (clear_page_rx),
		.flag_out    (page_received)
	);

	// ==========================================
	// Read mux
	logic [15:0] negotiation_expansion_status;
	always_comb begin
		negotiation_expansion_status = 16'h0000;
		negotiation_expansion_status[ANXS_PD_FAULT_BIT]   = parallel_detect_fault;
		negotiation_expansion_status[ANXS_PARTNER_NP_BIT] = partner_extra_pages_capable;
		negotiation_expansion_status[ANXS_LOCAL_NP_BIT]   = ANXS_LOCAL_NP_VALUE;
		negotiation_expansion_status[ANXS_PAGE_RX_BIT]    = page_received;
		negotiation_expansion_status[ANXS_PARTNER_AN_BIT] = partner_negotiation_capable;
	end

	// Unmapped addresses read zero
	wire logic [15:0] next_rdata = sel_partner ? partner_next_page_received :
	                               sel_expansion ? negotiation_expansion_status : 16'h0000;

	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			reg_rdata_out  <= 16'h0000;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in & ~unused_write | reg_rd_in & unused_write;
			if (reg_rd_in) begin
				reg_rdata_out <= next_rdata;
			end
		end
	end
endmodule

// ### test/anxs_chk.sv
// Checker bound to anxs_status_regs; sees only its ports.
`timescale 1ns/1ps
module anxs_chk (
	input wire logic        core_clk_in, rst_b_in, page_valid_in, parallel_fault_in, // Clock, reset, events
	input wire logic        partner_np_cap_in, partner_an_cap_in, reg_rd_in, reg_rvalid_out, // Levels, strobes
	input wire logic [15:0] page_word_in, reg_rdata_out, // Words
	input wire logic [4:0]  reg_addr_in // Address
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	wire rd5 = reg_rd_in && reg_addr_in == 5'h05;
	wire rd6 = reg_rd_in && reg_addr_in == 5'h06;
	chk_rd_answer: assert property (reg_rd_in |=> reg_rvalid_out) else $error("no rvalid");
	chk_no_stray: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("stray rvalid");
	chk_np_word: assert property ($past(page_valid_in) && rd5 |=> reg_rdata_out == $past(page_word_in, 2))
		else $error("bad page");
	chk_exp_fixed: assert property (rd6 |=> reg_rdata_out[15:5] == 11'h000 && reg_rdata_out[2]) else $error("exp");
	chk_page_set: assert property (page_valid_in ##1 rd6 |=> reg_rdata_out[1]) else $error("no page");
	chk_page_clear: assert property (rd6 && !page_valid_in ##1 rd6 && !page_valid_in |=> !reg_rdata_out[1])
		else $error("page kept");
	chk_fault_sticky: assert property (parallel_fault_in ##1 rd6 |=> reg_rdata_out[4]) else $error("no fault");
	// Reset in the window would hide the capability lag
	chk_cap_bits: assert property (rd6 && $stable({partner_np_cap_in, partner_an_cap_in, rst_b_in}) |=>
		{reg_rdata_out[3], reg_rdata_out[0]} == $past({partner_np_cap_in, partner_an_cap_in})) else $error("caps");
endmodule
bind anxs_status_regs anxs_chk anxs_chk_inst (.*);

// ### test/anxs_partner.sv
// Link partner model; callers enter just after a rising edge.
`timescale 1ns/1ps
module anxs_partner (
	input  wire logic   clk_in, // Clock
	output logic        v_out, f_out, n_out, a_out, // Word pulse, fault, capabilities
	output logic [15:0] w_out // Code word
);
	initial {v_out, f_out, n_out, a_out, w_out} = '0;
	task send(input logic v, f, n, a, input logic [15:0] w);
		{v_out, f_out, n_out, a_out, w_out} = {v, f, n, a, w};
		@(posedge clk_in) #1;
		{v_out, f_out, w_out} = {2'b00, ~w}; // Stale word lines must not look valid
	endtask
endmodule

// ### test/testbench.sv
// Testbench: partner sends pages, reads check both registers.
`timescale 1ns/1ps
module testbench;
	logic        clk = 1'b0, rst_b = 1'b0, rd = 1'b0, pv, pf, pn, pa, rvalid;
	logic [4:0]  ad = 5'h00;
	logic [15:0] pw, rdata, words[3] = '{16'ha555, 16'h5aaa, 16'h2001};
	int          num_errors = 0, checked = 0;
	always #4 clk = ~clk;
	anxs_partner anxs_partner_inst (.clk_in(clk), .v_out(pv), .f_out(pf), .n_out(pn), .a_out(pa), .w_out(pw));
	anxs_status_regs anxs_status_regs_inst (.core_clk_in(clk), .rst_b_in(rst_b), .page_valid_in(pv), .page_word_in(pw),
		.parallel_fault_in(pf), .partner_np_cap_in(pn), .partner_an_cap_in(pa), .reg_addr_in(ad), .reg_rd_in(rd),
		.reg_wr_in(rd), .reg_wdata_in(16'hffff), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid));
	task check(input logic [16:0] s, e);
		checked++;
		num_errors += int'(s !== e);
		if (s !== e) $display("[ERR] %0t %h %h", $time, s, e);
	endtask
	// Every read also writes all ones, which must change nothing
	task rd_reg(input logic [4:0] a, input logic [15:0] e);
		{rd, ad} = {1'b1, a};
		@(posedge clk) #1;
		check({rvalid, rdata}, {1'b1, e});
	endtask
	// Lets one edge pass with no read: valid must drop, data must stand
	task rd_idle(input logic [15:0] e);
		rd = 1'b0;
		@(posedge clk) #1;
		check({rvalid, rdata}, {1'b0, e});
	endtask
	task finish_test;
		if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#20000 num_errors++;
		finish_test();
	end
	initial begin
		repeat (20) @(posedge clk);
		#1 rst_b = 1'b1;
		rd_reg(5'h05, 16'h0000);
		rd_reg(5'h06, 16'h0004);
		foreach (words[i]) begin
			rd_idle(16'h0004);
			anxs_partner_inst.send(1'b1, 1'b0, 1'b0, 1'b0, words[i]);
			rd_reg(5'h05, words[i]);
			rd_reg(5'h06, 16'h0006);
			rd_reg(5'h06, 16'h0004);
		end
		rd_idle(16'h0004);
		anxs_partner_inst.send(1'b0, 1'b1, 1'b1, 1'b1, 16'h0000);
		rd_reg(5'h06, 16'h001d);
		rd_reg(5'h06, 16'h001d);
		// Read of 0x06 still held while a page lands: set must beat the clear
		anxs_partner_inst.send(1'b1, 1'b0, 1'b1, 1'b1, 16'h8fff);
		check({rvalid, rdata}, {1'b1, 16'h001d});
		rd_reg(5'h06, 16'h001f);
		rd_reg(5'h05, 16'h8fff);
		finish_test();
	end
endmodule
